/* rtl/cbrf_pkg.sv */
/*
  Package for the banked CPU register file: register indices, flag bit
  positions, field widths and reset values.
  Assumes a single CPU clock domain and no other users than the core.
*/
package cbrf_pkg;

  // Register indices on the software port (low four address bits).
  localparam logic [3:0] IDX_DATA0    = 4'h0;
  localparam logic [3:0] IDX_DATA1    = 4'h1;
  localparam logic [3:0] IDX_DATA2    = 4'h2;
  localparam logic [3:0] IDX_DATA3    = 4'h3;
  localparam logic [3:0] IDX_ADDR0    = 4'h4;
  localparam logic [3:0] IDX_ADDR1    = 4'h5;
  localparam logic [3:0] IDX_FRAME    = 4'h6;
  localparam logic [3:0] IDX_VECBASE  = 4'h7;
  localparam logic [3:0] IDX_PC       = 4'h8;
  localparam logic [3:0] IDX_USER_SP  = 4'h9;
  localparam logic [3:0] IDX_IRQ_SP   = 4'hA;
  localparam logic [3:0] IDX_SBASE    = 4'hB;
  localparam logic [3:0] IDX_FLAGS    = 4'hC;
  localparam int         NUM_ARCH_REGS = 13;
  localparam int         NUM_BANKED    = 7;

  // Flag register layout.
  localparam int FLAG_C     = 0;
  localparam int FLAG_D     = 1;
  localparam int FLAG_Z     = 2;
  localparam int FLAG_S     = 3;
  localparam int FLAG_B     = 4;
  localparam int FLAG_O     = 5;
  localparam int FLAG_I     = 6;
  localparam int FLAG_U     = 7;
  localparam int FLAG_PRIO0 = 8;
  localparam int FLAG_W     = 11;
  localparam int PRIO_W     = 3;

  // Widths.
  localparam int WORD_W = 16;
  localparam int LONG_W = 20;

  // Writable flag bits: bits 8..10 carry the priority level.
  localparam logic [10:0] FLAG_WMASK = 11'h7FF;
  localparam logic [10:0] FLAG_RESET = 11'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [19:0] LONG_RESET = 20'h00000;

  // Highest software interrupt vector that switches to the interrupt stack.
  localparam logic [5:0] SWI_STACK_MAX = 6'h1F;

endpackage : cbrf_pkg

/* rtl/cbrf_regfile.sv */
/*
  Banked CPU register file: two banks of data, address and frame registers,
  shared control registers, and the flag register with its hardware updates.
  Assumes the execution unit drives ALU results and interrupt events as
  single-cycle strobes synchronous to clk_sys_in; the software port is a
  plain address/strobe port with read data one cycle later.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps

// Behaviour
// - Thirteen architectural registers, banked ones counted once.
// - Data, address and frame registers exist twice; one bank visible.
// - Data registers 0 and 1 are 16 bits with separate byte halves.
// - Data 2 over 0, and 3 over 1, form 32-bit pairs.
// - Address 1 over address 0 forms one 32-bit register.
// - Frame base is a 16-bit register.
// - Vector table base is a 20-bit register.
// - Program counter is 20 bits and holds the next address.
// - Two 16-bit stack pointers; exactly one is active.
// - Static base is a 16-bit register.
// - Flag register is 11 bits of processor state.
// - Carry flag captures ALU carry, borrow or shift-out.
// - Zero flag is one for a zero result, else zero.
// - Sign flag is one for a negative result, else zero.
// - Bank select zero picks bank 0, one picks bank 1.
// - Overflow flag is one on overflow, else zero.
// - Maskable interrupts blocked while interrupt enable is zero.
// - Acknowledging any interrupt clears interrupt enable.
// - Stack select zero picks interrupt stack, one the user stack.
// - Stack select clears on hardware interrupt or software vector 0..31.
// - Three-bit priority; requests accepted only above the current level.
module cbrf_regfile (
  input  wire logic        clk_sys_in,     // CPU clock, 125 MHz.
  input  wire logic        rst_n_in,       // Asynchronous reset, active low.
  input  wire logic [3:0]  addr_in,        // Register index.
  input  wire logic [19:0] wdata_in,       // Write data.
  input  wire logic        wr_in,          // Write strobe.
  input  wire logic        rd_in,          // Read strobe.
  input  wire logic        byte_hi_in,     // Write high byte only.
  input  wire logic        byte_lo_in,     // Write low byte only.
  input  wire logic        pc_step_in,     // Advance program counter.
  input  wire logic [19:0] pc_next_in,     // Next instruction address.
  input  wire logic        alu_upd_in,     // ALU result flag update.
  input  wire logic        alu_carry_in,   // Carry, borrow or shift-out.
  input  wire logic        alu_ovf_in,     // Overflow of the operation.
  input  wire logic [15:0] alu_result_in,  // Result for zero and sign.
  input  wire logic        hw_ack_in,      // Hardware interrupt taken.
  input  wire logic        sw_int_in,      // Software interrupt executed.
  input  wire logic [5:0]  sw_vec_in,      // Software interrupt number.
  input  wire logic        irq_req_in,     // Maskable request pending.
  input  wire logic [2:0]  irq_lvl_in,     // Priority of that request.
  output logic [19:0]      rdata_out,      // Read data, cycle after strobe.
  output logic [31:0]      wide_data_pair_low_out,  // Data 2 over data 0.
  output logic [31:0]      wide_data_pair_high_out, // Data 3 over data 1.
  output logic [31:0]      wide_address_pair_out,   // Address 1 over 0.
  output logic [15:0]      active_sp_out,  // Selected stack pointer.
  output logic [19:0]      pc_out,         // Program counter.
  output logic [10:0]      flags_out,      // Flag register.
  output logic             irq_accept_out  // Request may be taken.
);

  // Banked storage: index 0..6 per bank, addressed by bank select.
  logic [15:0] bank_reg [2][cbrf_pkg::NUM_BANKED];
  logic [19:0] vecbase_reg;
  logic [19:0] pc_reg;
  logic [15:0] user_sp_reg;
  logic [15:0] irq_sp_reg;
  logic [15:0] sbase_reg;
  logic [10:0] flags_reg;
  logic [19:0] rdata_reg;
  logic        irq_accept_reg;
  logic        bank_sel;
  logic        stack_sel;
  logic [2:0]  prio_lvl;

  assign bank_sel  = flags_reg[cbrf_pkg::FLAG_B];
  assign stack_sel = flags_reg[cbrf_pkg::FLAG_U];
  assign prio_lvl  = flags_reg[cbrf_pkg::FLAG_PRIO0 +: cbrf_pkg::PRIO_W];

  // Byte-merge function used only by the data 0 and data 1 writes.
  function automatic logic [15:0] merge_word(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic        hi,
                                             input logic        lo);
    logic [15:0] res;
    res = new_v;
    if (hi && !lo)
    begin
      res = {new_v[15:8], old_v[7:0]};
    end
    else if (lo && !hi)
    begin
      res = {old_v[15:8], new_v[7:0]};
    end
    return res;
  endfunction

  // Banked writes touch only the selected bank; byte halves apply to
  // data registers 0 and 1 only, the others take the whole word.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int b = 0; b < 2; b++)
      begin
        for (int i = 0; i < cbrf_pkg::NUM_BANKED; i++)
        begin
          bank_reg[b][i] <= cbrf_pkg::WORD_RESET;
        end
      end
    end
    else if (wr_in && addr_in < cbrf_pkg::IDX_VECBASE)
    begin
      if (addr_in <= cbrf_pkg::IDX_DATA1)
      begin
        bank_reg[bank_sel][addr_in[2:0]] <= merge_word(
            bank_reg[bank_sel][addr_in[2:0]], wdata_in[15:0],
            byte_hi_in, byte_lo_in);
      end
      else
      begin
        bank_reg[bank_sel][addr_in[2:0]] <= wdata_in[15:0];
      end
    end
  end

  // Shared 16- and 20-bit control registers.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      vecbase_reg <= cbrf_pkg::LONG_RESET;
      user_sp_reg <= cbrf_pkg::WORD_RESET;
      irq_sp_reg  <= cbrf_pkg::WORD_RESET;
      sbase_reg   <= cbrf_pkg::WORD_RESET;
    end
    else if (wr_in)
    begin
      if (addr_in == cbrf_pkg::IDX_VECBASE)
      begin
        vecbase_reg <= wdata_in;
      end
      if (addr_in == cbrf_pkg::IDX_USER_SP)
      begin
        user_sp_reg <= wdata_in[15:0];
      end
      if (addr_in == cbrf_pkg::IDX_IRQ_SP)
      begin
        irq_sp_reg <= wdata_in[15:0];
      end
      if (addr_in == cbrf_pkg::IDX_SBASE)
      begin
        sbase_reg <= wdata_in[15:0];
      end
    end
  end

  // Program counter: a software write wins over the sequential step,
  // since a jump written by the core must not be lost.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pc_reg <= cbrf_pkg::LONG_RESET;
    end
    else if (wr_in && addr_in == cbrf_pkg::IDX_PC)
    begin
      pc_reg <= wdata_in;
    end
    else if (pc_step_in)
    begin
      pc_reg <= pc_next_in;
    end
  end

  // Flag register. Hardware events take priority over a write in the same
  // cycle so that an interrupt acknowledge is never undone.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags_reg <= cbrf_pkg::FLAG_RESET;
    end
    else
    begin
      logic [10:0] f;
      f = flags_reg;
      if (wr_in && addr_in == cbrf_pkg::IDX_FLAGS)
      begin
        f = wdata_in[10:0] & cbrf_pkg::FLAG_WMASK;
      end
      if (alu_upd_in)
      begin
        f[cbrf_pkg::FLAG_C] = alu_carry_in;
        f[cbrf_pkg::FLAG_Z] = (alu_result_in == 16'h0000);
        f[cbrf_pkg::FLAG_S] = alu_result_in[15];
        f[cbrf_pkg::FLAG_O] = alu_ovf_in;
      end
      if (hw_ack_in || sw_int_in)
      begin
        f[cbrf_pkg::FLAG_I] = 1'b0;
      end
      if (hw_ack_in ||
          (sw_int_in && sw_vec_in <= cbrf_pkg::SWI_STACK_MAX))
      begin
        f[cbrf_pkg::FLAG_U] = 1'b0;
      end
      flags_reg <= f;
    end
  end

  // Interrupt gate: enable set and priority above the current level.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_accept_reg <= 1'b0;
    end
    else
    begin
      irq_accept_reg <= irq_req_in && flags_reg[cbrf_pkg::FLAG_I] &&
                        (irq_lvl_in > prio_lvl);
    end
  end

  // Read port: data one cycle after the strobe, reserved bits zero.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_reg <= cbrf_pkg::LONG_RESET;
    end
    else if (rd_in)
    begin
      unique case (addr_in)
        cbrf_pkg::IDX_DATA0, cbrf_pkg::IDX_DATA1, cbrf_pkg::IDX_DATA2,
        cbrf_pkg::IDX_DATA3, cbrf_pkg::IDX_ADDR0, cbrf_pkg::IDX_ADDR1,
        cbrf_pkg::IDX_FRAME:
          rdata_reg <= {4'h0, bank_reg[bank_sel][addr_in[2:0]]};
        cbrf_pkg::IDX_VECBASE: rdata_reg <= vecbase_reg;
        cbrf_pkg::IDX_PC:      rdata_reg <= pc_reg;
        cbrf_pkg::IDX_USER_SP: rdata_reg <= {4'h0, user_sp_reg};
        cbrf_pkg::IDX_IRQ_SP:  rdata_reg <= {4'h0, irq_sp_reg};
        cbrf_pkg::IDX_SBASE:   rdata_reg <= {4'h0, sbase_reg};
        cbrf_pkg::IDX_FLAGS:   rdata_reg <= {9'h000, flags_reg};
        default:               rdata_reg <= cbrf_pkg::LONG_RESET;
      endcase
    end
    else
    begin
      rdata_reg <= cbrf_pkg::LONG_RESET;
    end
  end

  // Registered views for the execution unit, one cycle behind state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wide_data_pair_low_out  <= 32'h00000000;
      wide_data_pair_high_out <= 32'h00000000;
      wide_address_pair_out   <= 32'h00000000;
      active_sp_out           <= cbrf_pkg::WORD_RESET;
    end
    else
    begin
      wide_data_pair_low_out  <= {bank_reg[bank_sel][2],
                                  bank_reg[bank_sel][0]};
      wide_data_pair_high_out <= {bank_reg[bank_sel][3],
                                  bank_reg[bank_sel][1]};
      wide_address_pair_out   <= {bank_reg[bank_sel][5],
                                  bank_reg[bank_sel][4]};
      active_sp_out <= stack_sel ? user_sp_reg : irq_sp_reg;
    end
  end

  assign rdata_out      = rdata_reg;
  assign pc_out         = pc_reg;
  assign flags_out      = flags_reg;
  assign irq_accept_out = irq_accept_reg;

  // Checks on the flag updates. Each one looks one edge after the strobe,
  // because the flag register is a flip-flop and not a bypass path.
  zero_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    alu_upd_in |=>
      flags_reg[cbrf_pkg::FLAG_Z] == ($past(alu_result_in) == 16'h0000))
    else $error("zero flag wrong");
  sign_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    alu_upd_in |=>
      flags_reg[cbrf_pkg::FLAG_S] == $past(alu_result_in[15]))
    else $error("sign flag wrong");
  carry_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    alu_upd_in |=>
      flags_reg[cbrf_pkg::FLAG_C] == $past(alu_carry_in))
    else $error("carry flag wrong");
  ovf_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    alu_upd_in |=>
      flags_reg[cbrf_pkg::FLAG_O] == $past(alu_ovf_in))
    else $error("overflow flag wrong");

  // Checks on the interrupt side effects and the acceptance gate.
  ack_clears_i_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    hw_ack_in |=>
      !flags_reg[cbrf_pkg::FLAG_I] && !flags_reg[cbrf_pkg::FLAG_U])
    else $error("ack did not clear flags");
  swi_stack_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    sw_int_in && sw_vec_in <= cbrf_pkg::SWI_STACK_MAX |=>
      !flags_reg[cbrf_pkg::FLAG_U])
    else $error("software int kept user stack");
  swi_keep_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    sw_int_in && sw_vec_in > cbrf_pkg::SWI_STACK_MAX && !hw_ack_in &&
      !(wr_in && addr_in == cbrf_pkg::IDX_FLAGS) |=>
      flags_reg[cbrf_pkg::FLAG_U] == $past(flags_reg[cbrf_pkg::FLAG_U]))
    else $error("high vector changed stack select");
  irq_gate_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    irq_accept_out |-> $past(flags_reg[cbrf_pkg::FLAG_I]) &&
                       $past(irq_lvl_in) > $past(prio_lvl))
    else $error("interrupt accepted wrongly");
  irq_block_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !flags_reg[cbrf_pkg::FLAG_I] |=> !irq_accept_out)
    else $error("masked interrupt accepted");
  prio_gate_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    irq_req_in && flags_reg[cbrf_pkg::FLAG_I] && irq_lvl_in > prio_lvl
      |=> irq_accept_out)
    else $error("higher priority request refused");

  // Checks on the stack view, the banks, the program counter write and the read port.
  active_sp_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ##1 active_sp_out ==
      ($past(stack_sel) ? $past(user_sp_reg) : $past(irq_sp_reg)))
    else $error("wrong stack pointer");
  bank_isolate_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_in && addr_in == cbrf_pkg::IDX_DATA2 |=>
      bank_reg[!$past(bank_sel)][2] == $past(bank_reg[!bank_sel][2]))
    else $error("other bank written");
  bank_read_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_in && addr_in == cbrf_pkg::IDX_DATA0 |=>
      rdata_out[15:0] == $past(bank_reg[bank_sel][0]))
    else $error("read from wrong bank");
  byte_half_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_in && byte_hi_in && !byte_lo_in && addr_in == cbrf_pkg::IDX_DATA0
      |=> bank_reg[$past(bank_sel)][0][7:0] ==
          $past(bank_reg[bank_sel][0][7:0]))
    else $error("high byte write touched low byte");
  pc_write_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_in && addr_in == cbrf_pkg::IDX_PC |=> pc_reg == $past(wdata_in))
    else $error("program counter write lost");
  read_lat_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_in && addr_in == cbrf_pkg::IDX_PC && !wr_in && !pc_step_in
      |=> rdata_out == $past(pc_reg))
    else $error("read data late or wrong");
  reserved_rd_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_in && addr_in > cbrf_pkg::IDX_FLAGS |=>
      rdata_out == cbrf_pkg::LONG_RESET)
    else $error("unused index read nonzero");

endmodule // cbrf_regfile

/* testbench/cbrf_exec_model.sv */
/*
  Behavioural model of the execution unit and interrupt logic that drive the
  flag, program counter and request inputs of the banked register file.
  Assumes the testbench calls its tasks one at a time from one process.
*/
`timescale 1ns/100ps

module cbrf_exec_model (
  input  wire logic        clk_sys_in,     // CPU clock.
  output logic             pc_step_out,    // Program counter load pulse.
  output logic [19:0]      pc_next_out,    // Next instruction address.
  output logic             alu_upd_out,    // ALU flag update pulse.
  output logic             alu_carry_out,  // Carry, borrow or shift-out.
  output logic             alu_ovf_out,    // Overflow of the operation.
  output logic [15:0]      alu_result_out, // Result for zero and sign.
  output logic             hw_ack_out,     // Hardware interrupt taken.
  output logic             sw_int_out,     // Software interrupt executed.
  output logic [5:0]       sw_vec_out,     // Software interrupt number.
  output logic             irq_req_out,    // Maskable request level.
  output logic [2:0]       irq_lvl_out     // Priority of that request.
);

  // Idle values at time zero, before any operation is issued.
  initial
  begin
    {pc_step_out, pc_next_out, alu_upd_out, alu_carry_out} = '0;
    {alu_ovf_out, alu_result_out, hw_ack_out, sw_int_out} = '0;
    {sw_vec_out, irq_req_out, irq_lvl_out} = '0;
  end

  // Qualifiers flip once the strobe drops, so stale data is never reused.
  task automatic alu(input logic c, input logic o, input logic [15:0] r);
    @(posedge clk_sys_in);
    {alu_upd_out, alu_carry_out, alu_ovf_out, alu_result_out} <= {1'b1, c, o, r};
    @(posedge clk_sys_in);
    {alu_upd_out, alu_carry_out, alu_ovf_out, alu_result_out} <= {1'b0, ~c, ~o, ~r};
  endtask

  // One-cycle hardware acknowledge.
  task automatic ack_hw;
    @(posedge clk_sys_in);
    hw_ack_out <= 1'b1;
    @(posedge clk_sys_in);
    hw_ack_out <= 1'b0;
  endtask

  // Software interrupt with its vector number held beside the strobe.
  task automatic sw_int(input logic [5:0] v);
    @(posedge clk_sys_in);
    {sw_int_out, sw_vec_out} <= {1'b1, v};
    @(posedge clk_sys_in);
    {sw_int_out, sw_vec_out} <= {1'b0, ~v};
  endtask

  // Program counter advance to the given address.
  task automatic step_pc(input logic [19:0] a);
    @(posedge clk_sys_in);
    {pc_step_out, pc_next_out} <= {1'b1, a};
    @(posedge clk_sys_in);
    {pc_step_out, pc_next_out} <= {1'b0, ~a};
  endtask

  // Request is a level, so it stays until changed again.
  task automatic request(input logic on, input logic [2:0] lvl);
    @(posedge clk_sys_in);
    {irq_req_out, irq_lvl_out} <= {on, lvl};
  endtask

endmodule // cbrf_exec_model

/* testbench/cbrf_regfile_tb.sv */
/*
  Self-checking testbench for the banked register file: bus accesses, bank
  switching, byte writes, wide views, flag updates and interrupt gating.
  Assumes the execution-unit model drives all non-bus inputs except reset, which the testbench drives.
*/
`timescale 1ns/100ps

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end

module cbrf_regfile_tb;

  logic        clk_sys_in = 1'b0;
  logic        rst_n_in, wr_in, rd_in, byte_hi_in, byte_lo_in;
  logic [3:0]  addr_in;
  logic [19:0] wdata_in, pc_next, rdata_out, pc_out;
  logic        pc_step, alu_upd, alu_c, alu_o, hw_ack, sw_int, irq_req;
  logic [15:0] alu_r, active_sp_out;
  logic [5:0]  sw_vec;
  logic [2:0]  irq_lvl;
  logic [31:0] wlo, whi, wad;
  logic [10:0] flags_out;
  logic        irq_accept_out;
  int          fails = 0;
  int          checks_done = 0;

  // Free-running 125 MHz clock.
  always #4 clk_sys_in = ~clk_sys_in;

  cbrf_exec_model u_exec (.clk_sys_in(clk_sys_in), .pc_step_out(pc_step),
    .pc_next_out(pc_next), .alu_upd_out(alu_upd), .alu_carry_out(alu_c),
    .alu_ovf_out(alu_o), .alu_result_out(alu_r), .hw_ack_out(hw_ack),
    .sw_int_out(sw_int), .sw_vec_out(sw_vec), .irq_req_out(irq_req),
    .irq_lvl_out(irq_lvl));

  cbrf_regfile u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .byte_hi_in(byte_hi_in), .byte_lo_in(byte_lo_in), .pc_step_in(pc_step),
    .pc_next_in(pc_next), .alu_upd_in(alu_upd), .alu_carry_in(alu_c),
    .alu_ovf_in(alu_o), .alu_result_in(alu_r), .hw_ack_in(hw_ack),
    .sw_int_in(sw_int), .sw_vec_in(sw_vec), .irq_req_in(irq_req),
    .irq_lvl_in(irq_lvl), .rdata_out(rdata_out),
    .wide_data_pair_low_out(wlo), .wide_data_pair_high_out(whi),
    .wide_address_pair_out(wad), .active_sp_out(active_sp_out),
    .pc_out(pc_out), .flags_out(flags_out), .irq_accept_out(irq_accept_out));

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Single-cycle write; data flips afterwards so a late sample shows up.
  task automatic wr(input logic [3:0] a, input logic [19:0] d,
                    input logic hi, input logic lo);
    @(posedge clk_sys_in);
    {addr_in, wdata_in, wr_in, byte_hi_in, byte_lo_in} <= {a, d, 1'b1, hi, lo};
    @(posedge clk_sys_in);
    {wdata_in, wr_in, byte_hi_in, byte_lo_in} <= {~d, 3'b000};
  endtask

  // Single-cycle read; data is sampled in the cycle after the strobe.
  task automatic rd_chk(input logic [3:0] a, input logic [19:0] e);
    @(posedge clk_sys_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask

  // Registered views lag the state by a cycle, so wait two edges.
  task automatic settle;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  // Every index, reserved ones included, reads zero after reset.
  task automatic t_reset;
    for (int i = 0; i < 16; i++)
      rd_chk(i[3:0], 20'h00000);
    `CHK(flags_out, 11'h000)
  endtask

  // Distinct patterns, all ones XOR the index nibble, expose the width of every register but the flags.
  task automatic t_regs;
    logic [19:0] v;
    for (int i = 0; i < 16; i++)
      if (i != 12)
        wr(i[3:0], 20'hFFFFF ^ {5{i[3:0]}}, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      v = 20'hFFFFF ^ {5{i[3:0]}};
      if (i != 12)
        rd_chk(i[3:0], i > 12 ? 20'h0 : (i == 7 || i == 8) ? v : v & 20'h0FFFF);
    end
    settle;
    `CHK(wlo, 32'hDDDDFFFF)
    `CHK(whi, 32'hCCCCEEEE)
    `CHK(wad, 32'hAAAABBBB)
    `CHK(active_sp_out, 16'h5555)
    `CHK(pc_out, 20'h77777)
  endtask

  // Bank 1 starts empty, takes byte writes, and leaves bank 0 untouched.
  task automatic t_bank;
    wr(cbrf_pkg::IDX_FLAGS, 20'h007FD, 1'b0, 1'b0);
    rd_chk(cbrf_pkg::IDX_FLAGS, 20'h007FD);
    rd_chk(cbrf_pkg::IDX_DATA0, 20'h00000);
    settle;
    `CHK(active_sp_out, 16'h6666)
    `CHK(wad, 32'h00000000)
    wr(cbrf_pkg::IDX_DATA0, 20'h01234, 1'b0, 1'b0);
    wr(cbrf_pkg::IDX_DATA0, 20'h0ABAB, 1'b1, 1'b0);
    rd_chk(cbrf_pkg::IDX_DATA0, 20'h0AB34);
    wr(cbrf_pkg::IDX_DATA0, 20'h0CDCD, 1'b0, 1'b1);
    rd_chk(cbrf_pkg::IDX_DATA0, 20'h0ABCD);
    wr(cbrf_pkg::IDX_FLAGS, 20'h00000, 1'b0, 1'b0);
    rd_chk(cbrf_pkg::IDX_DATA0, 20'h0FFFF);
  endtask

  // Zero, negative and positive results with carry and overflow.
  task automatic t_alu;
    logic [15:0] res [3] = '{16'h0000, 16'h8000, 16'h0001};
    logic [10:0] exp [3] = '{11'h005, 11'h028, 11'h000};
    logic [2:0]  cy = 3'b001;
    logic [2:0]  ov = 3'b010;
    for (int k = 0; k < 3; k++)
    begin
      u_exec.alu(cy[k], ov[k], res[k]);
      settle;
      `CHK(flags_out, exp[k])
    end
  endtask

  // Priority boundary, masking, and the acknowledge side effects.
  task automatic t_irq;
    logic [5:0]  vec [2] = '{6'h20, 6'h1F};
    logic [10:0] fex [2] = '{11'h380, 11'h300};
    wr(cbrf_pkg::IDX_FLAGS, 20'h003C0, 1'b0, 1'b0);
    u_exec.request(1'b1, 3'd3);
    settle;
    `CHK(irq_accept_out, 1'b0)
    u_exec.request(1'b1, 3'd4);
    settle;
    `CHK(irq_accept_out, 1'b1)
    wr(cbrf_pkg::IDX_FLAGS, 20'h00380, 1'b0, 1'b0);
    settle;
    `CHK(irq_accept_out, 1'b0)
    u_exec.request(1'b0, 3'd0);
    wr(cbrf_pkg::IDX_FLAGS, 20'h003C0, 1'b0, 1'b0);
    u_exec.ack_hw;
    settle;
    `CHK(flags_out, 11'h300)
    for (int k = 0; k < 2; k++)
    begin
      wr(cbrf_pkg::IDX_FLAGS, 20'h003C0, 1'b0, 1'b0);
      u_exec.sw_int(vec[k]);
      settle;
      `CHK(flags_out, fex[k])
    end
  endtask

  // Program counter load from the execution unit.
  task automatic t_pc;
    u_exec.step_pc(20'h12345);
    settle;
    `CHK(pc_out, 20'h12345)
    rd_chk(cbrf_pkg::IDX_PC, 20'h12345);
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial
  begin
    {rst_n_in, wr_in, rd_in, byte_hi_in, byte_lo_in} = '0;
    {addr_in, wdata_in} = '0;
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_regs;
    t_bank;
    t_alu;
    t_irq;
    t_pc;
    report_and_stop;
  end

  // The run needs well under a thousand cycles; this cuts a hang short.
  initial
  begin
    #100000;
    fails++;
    report_and_stop;
  end

endmodule // cbrf_regfile_tb
